//--- hdl/gcb_pin_bank.sv
// pin configuration bank for twelve gpio pins with axi4-lite access
`timescale 1ns/100ps
`include "gcb_map.svh"

module gcb_pin_bank
  import gcb_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins, index 0..7 = 1.0..1.7, 8..11 = 2.0..2.3
  input  wire logic [11:0] pin_in,
  output logic [11:0]      pin_out,
  output logic [11:0]      pin_oe_n,
  // expansion bus data unit
  input  wire logic [7:0]  expansion_bus_data_out,
  input  wire logic        expansion_bus_data_drive,
  output logic [7:0]       expansion_bus_data_bit,
  // floppy controller outputs
  input  wire logic        floppy_drive_select_1,
  input  wire logic        floppy_motor_select_1,
  // keyboard controller port inputs
  output logic             kbc_port_pin_17,
  output logic             kbc_port_pin_16,
  output logic             kbc_port_pin_12,
  // irq routing
  output logic             irq_input_d,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // writable bits of a pin config; 2.0-2.2 carry a two-bit select
  function automatic gcb_cfg_t cfg_mask(input int unsigned p);
    cfg_mask = (p >= 8 && p <= 10) ? `GCB_MASK_WIDE : `GCB_MASK_NARROW;
  endfunction

  // select field; bit 3 is always zero on narrow registers
  function automatic logic [1:0] sel_of(input gcb_cfg_t c);
    sel_of = c[`GCB_BIT_SEL_HI:`GCB_BIT_SEL_LO];
  endfunction

  // map a word index to a pin number, or 12 if not a pin config
  function automatic logic [3:0] pin_of(input logic [7:0] idx);
    if (idx >= `GCB_IDX_PIN_1_0 && idx <= `GCB_IDX_PIN_2_3) begin
      pin_of = 4'(idx - `GCB_IDX_PIN_1_0);
    end else begin
      pin_of = 4'hc;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  gcb_cfg_t    cfg_reg [GCB_NPINS];   // per-pin config bytes
  gcb_pinvec_t data_out_reg;          // gpio output values
  gcb_pinvec_t in_meta_reg;           // first synchroniser stage
  gcb_pinvec_t in_sync_reg;           // second synchroniser stage
  gcb_pinvec_t level_prev_reg;        // logical level, last cycle
  logic [1:0]  irq_stat_reg;          // sticky edge events
  logic [1:0]  irq_mask_reg;          // 1 enables an event
  logic        aw_hold_reg;           // write address captured
  logic        w_hold_reg;            // write data captured
  logic [7:0]  aw_idx_reg;            // captured write word index
  logic [31:0] w_data_reg;            // captured write data
  logic [3:0]  w_strb_reg;            // captured write strobes
  gcb_pinvec_t pin_out_next;          // next pin output level
  gcb_pinvec_t pin_oe_n_next;         // next pin enable, low drives
  gcb_pinvec_t pol_vec;               // polarity bits gathered
  gcb_pinvec_t level;                 // pin value after polarity
  logic [1:0]  edge_set;              // edge events this cycle
  logic [1:0]  stat_clr;              // status read this cycle
  logic        do_write;              // commit captured write
  logic [7:0]  ar_idx;                // read word index
  logic [31:0] rd_value;              // read mux result
  gcb_resp_t   rd_resp;               // read answer code

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser

  // two flops before anything looks at a pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_meta_reg <= '0;
      in_sync_reg <= '0;
    end else begin
      in_meta_reg <= pin_in;
      in_sync_reg <= in_meta_reg;
    end
  end

  // logical value: inversion applies on the way in as well
  always_comb begin
    for (int p = 0; p < GCB_NPINS; p++) begin
      pol_vec[p] = cfg_reg[p][`GCB_BIT_POL];
    end
    level = in_sync_reg ^ pol_vec;
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi write channel

  // a write lands once both address and data are held
  assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

  // address capture; ready stays low until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_hold_reg   <= 1'b0;
      aw_idx_reg    <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_hold_reg   <= 1'b1;
      aw_idx_reg    <= s_axi_awaddr[9:2];
    end else if (do_write) begin
      aw_hold_reg   <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // data capture, independent of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_hold_reg   <= 1'b0;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_hold_reg   <= 1'b1;
      w_data_reg   <= s_axi_wdata;
      w_strb_reg   <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_reg   <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // response; unmapped words answer slverr and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `GCB_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (pin_of(aw_idx_reg) != 4'hc || aw_idx_reg == `GCB_IDX_DATA_OUT
          || aw_idx_reg == `GCB_IDX_PIN_LEVEL || aw_idx_reg == `GCB_IDX_IRQ_STAT
          || aw_idx_reg == `GCB_IDX_IRQ_MASK) begin
        s_axi_bresp <= `GCB_RESP_OKAY;
      end else begin
        s_axi_bresp <= `GCB_RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file

  // pin configs; reserved bits are masked off on every write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < GCB_NPINS; p++) begin
        cfg_reg[p] <= `GCB_CFG_RESET;
      end
    end else if (do_write && w_strb_reg[0] && pin_of(aw_idx_reg) != 4'hc) begin
      // only byte lane 0 carries a config
      cfg_reg[pin_of(aw_idx_reg)] <=
        w_data_reg[7:0] & cfg_mask(32'(pin_of(aw_idx_reg)));
    end
  end

  // gpio output values and interrupt mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_out_reg <= '0;
      irq_mask_reg <= 2'h0;
    end else if (do_write) begin
      if (aw_idx_reg == `GCB_IDX_DATA_OUT) begin
        if (w_strb_reg[0]) data_out_reg[7:0]  <= w_data_reg[7:0];
        if (w_strb_reg[1]) data_out_reg[11:8] <= w_data_reg[11:8];
      end
      if (aw_idx_reg == `GCB_IDX_IRQ_MASK && w_strb_reg[0]) begin
        irq_mask_reg <= w_data_reg[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi read channel

  assign ar_idx = s_axi_araddr[9:2];

  // read mux; reserved and unused bits read zero
  always_comb begin
    rd_value = 32'h00000000;
    rd_resp  = `GCB_RESP_OKAY;
    if (pin_of(ar_idx) != 4'hc) begin
      rd_value[7:0] = cfg_reg[pin_of(ar_idx)];
    end else if (ar_idx == `GCB_IDX_DATA_OUT) begin
      rd_value[11:0] = data_out_reg;
    end else if (ar_idx == `GCB_IDX_PIN_LEVEL) begin
      rd_value[11:0] = level;
    end else if (ar_idx == `GCB_IDX_IRQ_STAT) begin
      rd_value[1:0] = irq_stat_reg;
    end else if (ar_idx == `GCB_IDX_IRQ_MASK) begin
      rd_value[1:0] = irq_mask_reg;
    end else begin
      rd_resp = `GCB_RESP_SLVERR;
    end
  end

  // one read at a time; data is latched with the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `GCB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_value;
      s_axi_rresp   <= rd_resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge interrupts

  // events fire on either transition of the logical level
  always_comb begin
    edge_set = 2'h0;
    if (sel_of(cfg_reg[9]) == `GCB_SEL_ALT2) begin
      edge_set[`GCB_ST_EDGE0] = level[9] ^ level_prev_reg[9];
    end
    if (sel_of(cfg_reg[10]) == `GCB_SEL_ALT2) begin
      edge_set[`GCB_ST_EDGE1] = level[10] ^ level_prev_reg[10];
    end
    // a read of the status word clears what it returned
    stat_clr = (s_axi_arvalid && s_axi_arready && ar_idx == `GCB_IDX_IRQ_STAT)
               ? 2'h3 : 2'h0;
  end

  // level history; a polarity change can itself look like an edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_prev_reg <= '0;
    end else begin
      level_prev_reg <= level;
    end
  end

  // sticky status; a new event wins over a clearing read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= 2'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~stat_clr) | edge_set;
    end
  end

  // single level interrupt out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat_reg & ~stat_clr) | edge_set) & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  // pick each pin's source and drive, then apply type and polarity
  always_comb begin
    logic src;
    logic drv;
    src = 1'b0;
    drv = 1'b0;
    for (int p = 0; p < GCB_NPINS; p++) begin
      src = data_out_reg[p];
      drv = !cfg_reg[p][`GCB_BIT_DIR];
      if (p < 8 && sel_of(cfg_reg[p]) == `GCB_SEL_ALT1) begin
        // bus data is two-way; the bus unit decides direction
        src = expansion_bus_data_out[p[2:0]];
        drv = expansion_bus_data_drive;
      end
      if (p == 8 && sel_of(cfg_reg[8]) == `GCB_SEL_ALT2) begin
        src = floppy_drive_select_1;
      end
      if (p == 10 && sel_of(cfg_reg[10]) == `GCB_SEL_ALT3) begin
        src = floppy_motor_select_1;
      end
      src = src ^ cfg_reg[p][`GCB_BIT_POL];
      if (cfg_reg[p][`GCB_BIT_ODRAIN]) begin
        // open drain only ever pulls low
        pin_out_next[p]  = 1'b0;
        pin_oe_n_next[p] = !(drv && !src);
      end else begin
        pin_out_next[p]  = src;
        pin_oe_n_next[p] = !drv;
      end
    end
  end

  // registered pin outputs; after reset every pin is released
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out  <= pin_out_next;
      pin_oe_n <= pin_oe_n_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // inputs handed to alternate-function units

  // unselected keyboard inputs idle high like a pulled-up port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expansion_bus_data_bit <= 8'h00;
      kbc_port_pin_17        <= 1'b1;
      kbc_port_pin_16        <= 1'b1;
      kbc_port_pin_12        <= 1'b1;
      irq_input_d            <= 1'b0;
    end else begin
      expansion_bus_data_bit <= level[7:0];
      kbc_port_pin_17 <= (sel_of(cfg_reg[8]) == `GCB_SEL_ALT1)
                         ? level[8] : 1'b1;
      kbc_port_pin_16 <= (sel_of(cfg_reg[9]) == `GCB_SEL_ALT1)
                         ? level[9] : 1'b1;
      // both 2.1 and 2.2 can feed port pin 12; 2.1 takes priority
      if (sel_of(cfg_reg[9]) == `GCB_SEL_ALT3) begin
        kbc_port_pin_12 <= level[9];
      end else if (sel_of(cfg_reg[10]) == `GCB_SEL_ALT1) begin
        kbc_port_pin_12 <= level[10];
      end else begin
        kbc_port_pin_12 <= 1'b1;
      end
      irq_input_d <= (sel_of(cfg_reg[11]) == `GCB_SEL_ALT1)
                     ? level[11] : 1'b0;
    end
  end

endmodule

//--- hdl/gcb_map.svh
// offsets, field positions, reset values and masks of the pin config bank
`ifndef GCB_MAP_SVH
`define GCB_MAP_SVH

// register indices; byte address is four times the index
`define GCB_IDX_PIN_1_0   8'h23
`define GCB_IDX_PIN_1_1   8'h24
`define GCB_IDX_PIN_1_2   8'h25
`define GCB_IDX_PIN_1_3   8'h26
`define GCB_IDX_PIN_1_4   8'h27
`define GCB_IDX_PIN_1_5   8'h28
`define GCB_IDX_PIN_1_6   8'h29
`define GCB_IDX_PIN_1_7   8'h2a
`define GCB_IDX_PIN_2_0   8'h2b
`define GCB_IDX_PIN_2_1   8'h2c
`define GCB_IDX_PIN_2_2   8'h2d
`define GCB_IDX_PIN_2_3   8'h2e
`define GCB_IDX_DATA_OUT  8'h40
`define GCB_IDX_PIN_LEVEL 8'h41
`define GCB_IDX_IRQ_STAT  8'h42
`define GCB_IDX_IRQ_MASK  8'h43

// config register fields
`define GCB_BIT_DIR       0
`define GCB_BIT_POL       1
`define GCB_BIT_SEL_LO    2
`define GCB_BIT_SEL_HI    3
`define GCB_BIT_ODRAIN    7

// reset value and writable masks
`define GCB_CFG_RESET     8'h01
`define GCB_MASK_NARROW   8'h87
`define GCB_MASK_WIDE     8'h8f

// function select codes
`define GCB_SEL_GPIO      2'h0
`define GCB_SEL_ALT1      2'h1
`define GCB_SEL_ALT2      2'h2
`define GCB_SEL_ALT3      2'h3

// status bits
`define GCB_ST_EDGE0      0
`define GCB_ST_EDGE1      1

// axi responses
`define GCB_RESP_OKAY     2'h0
`define GCB_RESP_SLVERR   2'h2

`endif

//--- hdl/gcb_pkg.sv
// shared types of the pin config bank
package gcb_pkg;
  localparam int GCB_NPINS = 12;                // groups 1.0-1.7 and 2.0-2.3
  typedef logic [7:0]           gcb_cfg_t;      // one pin config byte
  typedef logic [GCB_NPINS-1:0] gcb_pinvec_t;   // one bit per pin
  typedef logic [1:0]           gcb_resp_t;     // axi response code
endpackage

//--- tb/gcb_pin_bank_checker.sv
// port assertions for the pin config bank
`timescale 1ns/100ps
`include "gcb_map.svh"
module gcb_pin_bank_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [11:0] pin_oe_n,
  input wire logic        kbc_port_pin_17,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  // both halves of a write taken at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // reset must be watched across its own release, so no disable here
  reset_state_a: assert property (disable iff (1'b0) $rose(aresetn) |->
    pin_oe_n == 12'hfff && !irq && kbc_port_pin_17 && s_axi_awready && !s_axi_bvalid)
    else $error("pins or bus not idle after reset");
  write_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  write_done_a: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not closed");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken while busy");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  unmapped_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `GCB_RESP_SLVERR |->
    s_axi_rdata == 32'h0) else $error("unmapped read not zero");
  read_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h0)
    else $error("upper read bits set");
endmodule
bind gcb_pin_bank gcb_pin_bank_checker u_gcb_pin_bank_checker (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_oe_n, .kbc_port_pin_17, .irq);

//--- tb/gcb_pin_model.sv
// far side of the twelve pins: board wiring and outside drivers
`timescale 1ns/100ps
module gcb_pin_model
  import gcb_pkg::*;
(
  input  wire gcb_pinvec_t pin_out,
  input  wire gcb_pinvec_t pin_oe_n,
  input  wire gcb_pinvec_t pin_ext,
  output gcb_pinvec_t      pin_in
);
  // a driven pin reads its own level, a released one the outside level
  always_comb begin
    for (int i = 0; i < GCB_NPINS; i++) begin
      pin_in[i] = pin_oe_n[i] ? pin_ext[i] : pin_out[i];
    end
  end
endmodule

//--- tb/tb_gcb_pin_bank.sv
// self-checking bench of the pin config bank
`timescale 1ns/100ps
`include "gcb_map.svh"
module tb_gcb_pin_bank;
  import gcb_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, irq_input_d;
  logic        expansion_bus_data_drive, floppy_drive_select_1, floppy_motor_select_1;
  logic        kbc_port_pin_17, kbc_port_pin_16, kbc_port_pin_12;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
  logic [7:0]  expansion_bus_data_out, expansion_bus_data_bit;
  gcb_pinvec_t pin_in, pin_out, pin_oe_n, pin_ext;
  int          num_errors, comparisons;

  gcb_pin_bank u_gcb_pin_bank (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pin_in, .pin_out, .pin_oe_n, .expansion_bus_data_out, .expansion_bus_data_drive,
    .expansion_bus_data_bit, .floppy_drive_select_1, .floppy_motor_select_1,
    .kbc_port_pin_17, .kbc_port_pin_16, .kbc_port_pin_12, .irq_input_d, .irq);
  gcb_pin_model u_gcb_pin_model (.pin_out, .pin_oe_n, .pin_ext, .pin_in);

  ////////////////////////////////////////////////////////////////
  // clock at 40 mhz
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic summarize;
    $display("errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one write; both halves offered together, bready stays high afterwards
  // so that back-to-back calls never drive it twice in one step;
  // only the watchdog ends a wait
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic done;
    done = 1'b0;
    s_axi_awaddr  <= {idx, 2'h0};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        done = 1'b1;
        last_resp = s_axi_bresp;
      end
    end
  endtask
  // one read; rready stays high afterwards, data taken at the rvalid edge
  task automatic rd(input logic [7:0] idx);
    logic done;
    done = 1'b0;
    s_axi_araddr  <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        done = 1'b1;
        rd_val = s_axi_rdata;
        last_resp = s_axi_rresp;
      end
    end
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(rd_val, exp);
  endtask
  // pins need a few edges through the synchronizers and output flops
  task automatic wrs(input logic [7:0] idx, input logic [31:0] d);
    wr(idx, d);
    repeat (6) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk(32'(pin_oe_n), 32'hfff);
    for (int p = 0; p < 12; p++) begin
      rdchk(`GCB_IDX_PIN_1_0 + 8'(p), 32'h01);
      wr(`GCB_IDX_PIN_1_0 + 8'(p), 32'hffff_ffff);
      rdchk(`GCB_IDX_PIN_1_0 + 8'(p), (p > 7 && p < 11) ? 32'h8f : 32'h87);
      wr(`GCB_IDX_PIN_1_0 + 8'(p), 32'h01);
    end
    wr(8'h10, 32'h1);
    chk(32'(last_resp), 32'h2);
    rdchk(8'h10, 32'h0);
    chk(32'(last_resp), 32'h2);
    // lane 0 off: the config must keep its value
    s_axi_wstrb <= 4'he;
    wr(`GCB_IDX_PIN_1_0, 32'h0);
    s_axi_wstrb <= 4'hf;
    rdchk(`GCB_IDX_PIN_1_0, 32'h01);
  endtask
  // direction, polarity and driver type on pin 1.0, then input path
  task automatic t_gpio;
    logic [7:0] cfg[5] = '{8'h00, 8'h02, 8'h80, 8'h80, 8'h01};
    logic [1:0] exp[5] = '{2'b10, 2'b00, 2'b01, 2'b00, 2'b01};
    for (int k = 0; k < 5; k++) begin
      wr(`GCB_IDX_DATA_OUT, (k < 3) ? 32'h1 : 32'h0);
      wrs(`GCB_IDX_PIN_1_0, 32'(cfg[k]));
      chk(32'({pin_out[0], pin_oe_n[0]}), 32'(exp[k]));
    end
    pin_ext <= 12'h008;
    wrs(`GCB_IDX_PIN_1_3, 32'h01);
    rdchk(`GCB_IDX_PIN_LEVEL, 32'h008);
    wrs(`GCB_IDX_PIN_1_3, 32'h03);
    rdchk(`GCB_IDX_PIN_LEVEL, 32'h000);
    wr(`GCB_IDX_PIN_1_3, 32'h01);
  endtask
  task automatic t_bus;
    expansion_bus_data_out   <= 8'ha5;
    expansion_bus_data_drive <= 1'b1;
    for (int p = 0; p < 8; p++) wrs(`GCB_IDX_PIN_1_0 + 8'(p), 32'h05);
    chk(32'({pin_out[7:0], pin_oe_n[7:0]}), 32'ha500);
    expansion_bus_data_drive <= 1'b0;
    pin_ext <= 12'h05a;
    wrs(`GCB_IDX_PIN_1_7, 32'h05);
    chk(32'(expansion_bus_data_bit), 32'h5a);
    for (int p = 0; p < 8; p++) wr(`GCB_IDX_PIN_1_0 + 8'(p), 32'h01);
  endtask
  // the alternate select codes of pins 2.0 to 2.3 other than the edge inputs; outside levels low except on 2.3
  task automatic t_alt;
    pin_ext <= 12'h000;
    floppy_drive_select_1 <= 1'b1;
    floppy_motor_select_1 <= 1'b1;
    wrs(`GCB_IDX_PIN_2_0, 32'h05);
    chk(32'(kbc_port_pin_17), 32'h0);
    wrs(`GCB_IDX_PIN_2_0, 32'h08);
    chk(32'({pin_out[8], pin_oe_n[8]}), 32'h2);
    wrs(`GCB_IDX_PIN_2_0, 32'h0c);
    chk(32'({pin_out[8], pin_oe_n[8]}), 32'h0);
    wr(`GCB_IDX_PIN_2_0, 32'h01);
    wrs(`GCB_IDX_PIN_2_1, 32'h05);
    chk(32'(kbc_port_pin_16), 32'h0);
    wrs(`GCB_IDX_PIN_2_1, 32'h0d);
    chk(32'(kbc_port_pin_12), 32'h0);
    wr(`GCB_IDX_PIN_2_1, 32'h01);
    wrs(`GCB_IDX_PIN_2_2, 32'h05);
    chk(32'(kbc_port_pin_12), 32'h0);
    wrs(`GCB_IDX_PIN_2_2, 32'h0c);
    chk(32'({pin_out[10], pin_oe_n[10]}), 32'h2);
    wr(`GCB_IDX_PIN_2_2, 32'h01);
    pin_ext <= 12'h800;
    wrs(`GCB_IDX_PIN_2_3, 32'h05);
    chk(32'(irq_input_d), 32'h1);
    wr(`GCB_IDX_PIN_2_3, 32'h01);
  endtask
  // either-edge inputs on 2.1 and 2.2, read-to-clear and masking
  task automatic t_irq;
    pin_ext <= 12'h000;
    wr(`GCB_IDX_IRQ_MASK, 32'h3);
    wr(`GCB_IDX_PIN_2_1, 32'h09);
    wrs(`GCB_IDX_PIN_2_2, 32'h09);
    rd(`GCB_IDX_IRQ_STAT);
    pin_ext <= 12'h200;
    wrs(`GCB_IDX_IRQ_MASK, 32'h3);
    chk(32'(irq), 32'h1);
    rdchk(`GCB_IDX_IRQ_STAT, 32'h1);
    pin_ext <= 12'h400;
    wrs(`GCB_IDX_IRQ_MASK, 32'h0);
    chk(32'(irq), 32'h0);
    rdchk(`GCB_IDX_IRQ_STAT, 32'h3);
  endtask

  ////////////////////////////////////////////////////////////////
  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    summarize;
  end
  initial begin
    num_errors = 0;
    comparisons = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 10'h0;
    s_axi_araddr = 10'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    pin_ext = 12'h000;
    expansion_bus_data_out = 8'h00;
    expansion_bus_data_drive = 1'b0;
    floppy_drive_select_1 = 1'b0;
    floppy_motor_select_1 = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_gpio;
    t_bus;
    t_alt;
    t_irq;
    summarize;
  end
endmodule
